// ==== sim/serial_peer.sv ====
`timescale 1ns/1ps
module serial_peer (
	input wire logic aclk,
	output logic rx_line
);
	// line idles high between frames
	initial rx_line = 1'b1;
	// n-cycle hold, sixteen for one bit time, optional one-cycle glitch at cycle 8 (mid-bit when n is 16)
	task automatic hold_bit(input logic v, input int n, input logic glitch);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			rx_line <= (glitch && i == 8) ? ~v : v;
		end
	endtask
	// stop levels given: lsb first, optional parity, then a high gap
	task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic pv,
		input int ns, input logic [1:0] stp, input logic glitch);
		hold_bit(1'b0, 16, 1'b0);
		for (int i = 0; i < nb; i++) hold_bit(d[i], 16, glitch && i == 2);
		if (pe) hold_bit(pv, 16, 1'b0);
		for (int i = 0; i < ns; i++) hold_bit(stp[i], 16, 1'b0);
		hold_bit(1'b1, 32, 1'b0);
	endtask
endmodule // serial_peer

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb
	import uart_rx_pkg::*;
;
	typedef struct {logic [8:0] d; logic [7:0] c1; logic pv; logic [1:0] stp; logic g;
		logic [7:0] st;} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	logic rx_pin, tx_pin, port_irq, wake_event, woke = 1'b0;
	logic tx_line = 1'b0, tx_empty = 1'b0, tx_idle = 1'b0, power_down = 1'b0;
	logic [31:0] rd;
	logic [1:0] rr;
	int n_fail = 0, compares = 0, cyc = 0;
	// data, ctrl1, parity bit, stop levels, glitch, status (parity/noise/framing/idle/avail)
	row_t rows [7] = '{'{9'h0a5, 8'h10, 1'b0, 2'b11, 1'b0, 8'h30},
		'{9'h1c3, 8'h17, 1'b0, 2'b11, 1'b0, 8'h30}, '{9'h03c, 8'h12, 1'b1, 2'b11, 1'b0, 8'h31},
		'{9'h05a, 8'h10, 1'b0, 2'b10, 1'b0, 8'h34}, '{9'h066, 8'h18, 1'b0, 2'b01, 1'b0, 8'h34},
		'{9'h000, 8'h10, 1'b0, 2'b00, 1'b0, 8'h34}, '{9'h0f0, 8'h10, 1'b0, 2'b11, 1'b1, 8'h32}};
	logic [7:0] tx_c [3] = '{8'h05, 8'h09, 8'h01};
	always #5 aclk = ~aclk;
	uart_rx_status_irq dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
		.rx_pin(rx_pin), .tx_line(tx_line), .tx_empty(tx_empty), .tx_idle(tx_idle),
		.power_down(power_down), .tx_pin(tx_pin), .port_irq(port_irq), .wake_event(wake_event));
	serial_peer peer (.aclk(aclk), .rx_line(rx_pin));
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// bus write: each valid held until its own ready, bready until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (rsp.awready) aw = 1'b0;
			if (rsp.wready) w = 1'b0;
			req.awvalid <= aw;
			req.wvalid <= w;
		end
		while (!rsp.bvalid) @(posedge aclk);
		rr = rsp.bresp;
		req.bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do @(posedge aclk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (!rsp.rvalid);
		rd = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
	endtask
	// cut a hang short and catch the one-cycle wake pulse
	always @(posedge aclk) begin
		cyc++;
		if (wake_event === 1'b1) woke <= 1'b1;
		if (cyc == 30000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 8; a < 24; a += 4) begin
			rd_reg(8'(a));
			chk(rd, 32'h0, "reset value");
		end
		rd_reg(8'h18);
		chk({30'h0, rr}, {30'h0, `RESP_DECERR}, "unmapped read");
		wr(`OFF_STATUS, 32'hff);
		chk({30'h0, rr}, {30'h0, `RESP_DECERR}, "status write");
		wr(`OFF_CTRL2, 32'h1);
		for (int i = 0; i < 7; i++) begin
			wr(`OFF_CTRL1, {24'h0, rows[i].c1});
			peer.send(rows[i].d, rows[i].c1[0] ? 9 : 8, rows[i].c1[1], rows[i].pv,
				rows[i].c1[3] ? 2 : 1, rows[i].stp, rows[i].g);
			rd_reg(`OFF_STATUS);
			chk(rd & 32'h37, {24'h0, rows[i].st}, "status");
			rd_reg(`OFF_RXDATA);
			chk(rd, {23'h0, rows[i].d}, "data");
			rd_reg(`OFF_STATUS);
			chk(rd & 32'h2a, 32'h0, "flags cleared");
		end
		// three words, no reads: overrun keeps the first two
		wr(`OFF_CTRL1, 32'h10);
		wr(`OFF_INTC, 32'h3);
		wr(`OFF_CTRL2, 32'h3);
		for (int i = 1; i < 4; i++) peer.send(9'(i * 17), 8, 1'b0, 1'b0, 1, 2'b11, 1'b0);
		chk({31'h0, port_irq}, 32'h1, "rx irq");
		rd_reg(`OFF_STATUS);
		chk(rd & 32'h28, 32'h28, "overrun set");
		rd_reg(`OFF_RXDATA);
		chk(rd, 32'h11, "first kept");
		rd_reg(`OFF_RXDATA);
		chk(rd, 32'h22, "second kept");
		rd_reg(`OFF_STATUS);
		chk(rd & 32'h28, 32'h0, "overrun cleared");
		chk({31'h0, port_irq}, 32'h0, "irq dropped");
		// address detect with parity kept off
		wr(`OFF_CTRL2, 32'h13);
		for (int i = 0; i < 2; i++) begin
			peer.send(i ? 9'h080 : 9'h07f, 8, 1'b0, 1'b0, 1, 2'b11, 1'b0);
			chk({31'h0, port_irq}, 32'(i), "address irq");
			rd_reg(`OFF_STATUS);
			rd_reg(`OFF_RXDATA);
		end
		// transmit sources, each under its own enable
		tx_empty <= 1'b1;
		tx_idle <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(`OFF_CTRL2, {24'h0, tx_c[i]});
			rd_reg(`OFF_STATUS);
			chk({31'h0, port_irq}, 32'(i < 2), "tx irq");
		end
		chk(rd & 32'hc0, 32'hc0, "tx flags");
		tx_empty <= 1'b0;
		tx_idle <= 1'b0;
		chk({31'h0, tx_pin}, 32'h0, "tx follows line");
		// armed power-down, falling edge wakes, interrupt after the delay
		wr(`OFF_CTRL2, 32'h23);
		power_down <= 1'b1;
		peer.hold_bit(1'b1, 4, 1'b0);
		chk({31'h0, tx_pin}, 32'h1, "tx held high");
		peer.hold_bit(1'b0, 20, 1'b0);
		chk({31'h0, woke}, 32'h1, "wake event");
		power_down <= 1'b0;
		peer.hold_bit(1'b1, 1000, 1'b0);
		chk({31'h0, port_irq}, 32'h0, "irq withheld");
		for (int k = 0; k < 200 && port_irq !== 1'b1; k++) @(posedge aclk);
		chk({31'h0, port_irq}, 32'h1, "wake irq");
		rd_reg(`OFF_CTRL2);
		chk(rd, 32'h23, "ctrl kept");
		rd_reg(`OFF_STATUS);
		// bad stop then a second reset: stored flags must go
		wr(`OFF_CTRL2, 32'h1);
		peer.send(9'h0c3, 8, 1'b0, 1'b0, 1, 2'b00, 1'b0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(`OFF_STATUS);
		chk(rd & 32'h25, 32'h0, "reset clears");
		give_verdict();
	end
endmodule // tb

// ==== sim/uart_rx_status_irq_monitor.sv ====
`timescale 1ns/1ps
module uart_rx_status_irq_monitor
	import uart_rx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire axil_req_t axil_req,
	input wire axil_rsp_t axil_rsp,
	input wire logic rx_pin,
	input wire logic tx_line,
	input wire logic tx_empty,
	input wire logic tx_idle,
	input wire logic power_down,
	input wire logic tx_pin,
	input wire logic port_irq,
	input wire logic wake_event
);
	logic [10:0] hold_cnt_r;
	logic [5:0] ctrl2_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// withhold window after a wake, one short of the full count for slack
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt_r <= 11'h000;
			ctrl2_r <= 6'h00;
		end else begin
			if (wake_event) hold_cnt_r <= 11'h3ff;
			else if (hold_cnt_r != 11'h000) hold_cnt_r <= hold_cnt_r - 11'h001;
			if (axil_rsp.awready && axil_req.awaddr == `OFF_CTRL2 && axil_req.wstrb[0])
				ctrl2_r <= axil_req.wdata[5:0];
		end
	end
	// read handshake then answer
	sequence rd_taken;
		axil_rsp.arready;
	endsequence
	sequence rd_answered;
		##2 axil_rsp.rvalid;
	endsequence
	tx_forced_high_a: assert property (power_down |=> tx_pin)
		else $error("tx pin not high in power-down");
	wake_pulse_a: assert property (wake_event |=> !wake_event)
		else $error("wake event longer than one cycle");
	wake_cause_a: assert property (wake_event |-> $past(power_down))
		else $error("wake event outside power-down");
	irq_withheld_a: assert property (hold_cnt_r != 11'h000 |-> !port_irq)
		else $error("interrupt during wake delay");
	irq_masked_a: assert property (ctrl2_r[3:1] == 3'h0 && $past(ctrl2_r[3:1]) == 3'h0 |-> !port_irq)
		else $error("interrupt with all enables off");
	status_ro_a: assert property (axil_rsp.awready && axil_req.awaddr inside {`OFF_STATUS, `OFF_RXDATA}
		|=> axil_rsp.bvalid && axil_rsp.bresp == `RESP_DECERR)
		else $error("write to read-only register accepted");
	read_answer_a: assert property (rd_taken |-> rd_answered)
		else $error("read answer not two cycles after accept");
	write_answer_a: assert property (axil_rsp.awready |=> axil_rsp.bvalid && !axil_rsp.awready)
		else $error("write answer missing");
	ack_paired_a: assert property (axil_rsp.awready |-> axil_rsp.wready)
		else $error("address and data accept apart");
endmodule // uart_rx_status_irq_monitor

bind uart_rx_status_irq uart_rx_status_irq_monitor mon (
	.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.rx_pin(rx_pin), .tx_line(tx_line), .tx_empty(tx_empty), .tx_idle(tx_idle),
	.power_down(power_down), .tx_pin(tx_pin), .port_irq(port_irq), .wake_event(wake_event)
);

// ==== src/rx_fifo_mem.sv ====
`timescale 1ns/1ps
module rx_fifo_mem
	import uart_rx_pkg::*;
(
	input wire logic aclk,
	input wire logic we,
	input wire logic waddr,
	input wire rx_entry_t wdata,
	input wire logic raddr,
	output rx_entry_t rdata_r
);
	rx_entry_t mem [`FIFO_DEPTH];

	// storage has no reset: contents only matter behind the fill count
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port; a word written into the read slot passes straight through,
	// so the head never shows a stale entry for a cycle after a push into an empty buffer
	always_ff @(posedge aclk) begin
		rdata_r <= (we && (waddr == raddr)) ? wdata : mem[raddr];
	end
endmodule // rx_fifo_mem

// ==== src/uart_rx_params.svh ====
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH

// register byte offsets
`define OFF_STATUS 8'h00
`define OFF_RXDATA 8'h04
`define OFF_CTRL1 8'h08
`define OFF_CTRL2 8'h0c
`define OFF_BAUD 8'h10
`define OFF_INTC 8'h14

// port_control_one fields
`define C1_NINE_BIT 0
`define C1_PARITY_EN 1
`define C1_PARITY_ODD 2
`define C1_TWO_STOP 3
`define C1_PORT_EN 4

// port_control_two fields
`define C2_RX_EN 0
`define C2_RX_IE 1
`define C2_TXE_IE 2
`define C2_TXI_IE 3
`define C2_ADDR_DET 4
`define C2_WAKE_EN 5

// interrupt_control_one fields
`define IC_GLOBAL_IE 0
`define IC_PORT_IE 1

// port_status_register fields
`define ST_PARITY_ERR 0
`define ST_NOISE 1
`define ST_FRAMING 2
`define ST_OVERRUN 3
`define ST_RX_IDLE 4
`define ST_RX_AVAIL 5
`define ST_TX_IDLE 6
`define ST_TX_EMPTY 7

// reset values
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define BAUD_RST 8'h00
`define INTC_RST 8'h00

// timing
`define OVERSAMPLE 16
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define WAKE_CYCLES 1024
`define FIFO_DEPTH 2

// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== src/uart_rx_pkg.sv ====
package uart_rx_pkg;
	`include "uart_rx_params.svh"

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// one buffered word with the flags that travel with it
	typedef struct packed {
		logic [8:0] data;
		logic framing;
		logic parity;
	} rx_entry_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PARITY = 3'h2,
		RX_STOP = 3'h6,
		RX_STOP2 = 3'h7,
		RX_WAIT_HIGH = 3'h5
	} rx_state_t;
endpackage

// ==== src/uart_rx_status_irq.sv ====
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module uart_rx_status_irq
	import uart_rx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire axil_req_t axil_req,
	output axil_rsp_t axil_rsp,
	input wire logic rx_pin,
	input wire logic tx_line,
	input wire logic tx_empty,
	input wire logic tx_idle,
	input wire logic power_down,
	output logic tx_pin,
	output logic port_irq,
	output logic wake_event
);
	axil_rsp_t rsp_r;
	logic [7:0] ctrl1_r, ctrl2_r, baud_r, intc_r;
	logic rd_busy_r;
	logic [7:0] rd_addr_r;
	logic status_seen_r;
	logic overrun_flag_r, noise_flag_r;
	logic wr_ptr_r, rd_ptr_r;
	logic [1:0] count_r;
	rx_entry_t head_r;
	rx_state_t st_r;
	logic [7:0] div_r;
	logic [3:0] samp_r, bit_r;
	logic s_a_r, s_b_r;
	logic [8:0] shift_r;
	logic par_r, fer_r, per_r, noise_r;
	logic pd_q_r, armed_r, rx_q_r;
	logic wake_busy_r, wake_pend_r;
	logic [9:0] wake_cnt_r;
	logic tx_pin_r, port_irq_r, wake_event_r;

	// control bit views
	wire nine_bit = ctrl1_r[`C1_NINE_BIT];
	wire parity_en = ctrl1_r[`C1_PARITY_EN];
	wire parity_odd = ctrl1_r[`C1_PARITY_ODD];
	wire two_stop = ctrl1_r[`C1_TWO_STOP];
	wire port_en = ctrl1_r[`C1_PORT_EN];
	wire rx_en = ctrl2_r[`C2_RX_EN];
	wire rx_ie = ctrl2_r[`C2_RX_IE];
	wire txe_ie = ctrl2_r[`C2_TXE_IE];
	wire txi_ie = ctrl2_r[`C2_TXI_IE];
	wire addr_det = ctrl2_r[`C2_ADDR_DET];
	wire wake_en = ctrl2_r[`C2_WAKE_EN];
	wire global_ie = intc_r[`IC_GLOBAL_IE];
	wire port_ie = intc_r[`IC_PORT_IE];

	// bus handshakes and decode
	wire wr_go = rsp_r.awready & axil_req.awvalid & axil_req.wvalid;
	wire rd_go = rsp_r.arready & axil_req.arvalid;
	wire [7:0] wa = axil_req.awaddr;
	wire wr_hit = (wa == `OFF_CTRL1) | (wa == `OFF_CTRL2) | (wa == `OFF_BAUD) |
		(wa == `OFF_INTC);
	wire wr_lane = wr_go & axil_req.wstrb[0];
	wire rd_status = rd_go & (axil_req.araddr == `OFF_STATUS);
	wire rd_data = rd_go & (axil_req.araddr == `OFF_RXDATA);
	wire rd_hit = (rd_addr_r == `OFF_STATUS) | (rd_addr_r == `OFF_RXDATA) |
		(rd_addr_r == `OFF_CTRL1) | (rd_addr_r == `OFF_CTRL2) |
		(rd_addr_r == `OFF_BAUD) | (rd_addr_r == `OFF_INTC);

	// buffer control
	wire rx_avail = count_r != 2'h0;
	wire pop = rd_busy_r & (rd_addr_r == `OFF_RXDATA) & rx_avail; // pop as the word is answered
	wire seq_clear = rd_data & status_seen_r;

	// oversampling engine
	wire run = port_en & rx_en & ~power_down & ~wake_busy_r;
	wire tick = run & (div_r == baud_r);
	wire decide = tick & (samp_r == `SAMPLE_C);
	wire maj = (s_a_r & s_b_r) | (s_a_r & rx_pin) | (s_b_r & rx_pin);
	wire disagree = ~((s_a_r == s_b_r) & (s_b_r == rx_pin));
	wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;

	// frame completion
	wire done = decide & (((st_r == RX_STOP) & (~maj | ~two_stop)) | (st_r == RX_STOP2));
	wire fer_fin = fer_r | ~maj;
	wire noise_fin = noise_r | disagree;
	wire [8:0] word = nine_bit ? shift_r : {1'b0, shift_r[8:1]};
	wire push = done & (count_r != 2'(`FIFO_DEPTH));
	wire overrun = done & (count_r == 2'(`FIFO_DEPTH));
	rx_entry_t push_entry;
	assign push_entry.data = fer_fin ? (word & {9{|word}}) : word;
	assign push_entry.framing = fer_fin;
	assign push_entry.parity = per_r;

	// head views: flags and data of the oldest word
	wire head_fer = rx_avail & head_r.framing;
	wire head_per = rx_avail & head_r.parity;
	wire top_bit = nine_bit ? head_r.data[8] : head_r.data[7];
	wire rx_idle = (st_r == RX_IDLE) | (st_r == RX_WAIT_HIGH);

	wire [7:0] status_word = {tx_empty, tx_idle, rx_avail, rx_idle, overrun_flag_r,
		head_fer, noise_flag_r, head_per};
	wire [31:0] rd_word =
		(rd_addr_r == `OFF_STATUS) ? {24'h0, status_word} :
		(rd_addr_r == `OFF_RXDATA) ? {23'h0, head_r.data & {9{rx_avail}}} :
		(rd_addr_r == `OFF_CTRL1) ? {24'h0, ctrl1_r} :
		(rd_addr_r == `OFF_CTRL2) ? {24'h0, ctrl2_r} :
		(rd_addr_r == `OFF_BAUD) ? {24'h0, baud_r} :
		(rd_addr_r == `OFF_INTC) ? {24'h0, intc_r} : 32'h0;

	// separate transmit enables, shared receive enable
	// top bit qualifies data-available under address detect
	// noise has no source of its own
	wire irq_src = (tx_empty & txe_ie) | (tx_idle & txi_ie) |
		(rx_avail & rx_ie & (~addr_det | top_bit)) |
		(overrun_flag_r & rx_ie) | wake_pend_r;

	// write address and data are taken together, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_r <= '0;
		end else begin
			rsp_r.awready <= axil_req.awvalid & axil_req.wvalid & ~rsp_r.awready & ~rsp_r.bvalid;
			rsp_r.wready <= axil_req.awvalid & axil_req.wvalid & ~rsp_r.awready & ~rsp_r.bvalid;
			if (wr_go) begin
				rsp_r.bvalid <= 1'b1;
				rsp_r.bresp <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
			end else if (axil_req.bready) begin
				rsp_r.bvalid <= 1'b0;
			end
			rsp_r.arready <= axil_req.arvalid & ~rsp_r.arready & ~rd_busy_r & ~rsp_r.rvalid;
			if (rd_busy_r) begin
				rsp_r.rvalid <= 1'b1;
				rsp_r.rdata <= rd_word;
				rsp_r.rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
			end else if (axil_req.rready) begin
				rsp_r.rvalid <= 1'b0;
			end
		end
	end

	// read address held one cycle so the buffer head has settled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_busy_r <= 1'b0;
			rd_addr_r <= 8'h0;
		end else begin
			rd_busy_r <= rd_go;
			if (rd_go) begin
				rd_addr_r <= axil_req.araddr;
			end
		end
	end

	// writable registers, nothing here reacts to power-down
	// status flags have no write path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl1_r <= `CTRL1_RST;
			ctrl2_r <= `CTRL2_RST;
			baud_r <= `BAUD_RST;
			intc_r <= `INTC_RST;
		end else if (wr_lane) begin
			if (wa == `OFF_CTRL1) ctrl1_r <= axil_req.wdata[7:0];
			if (wa == `OFF_CTRL2) ctrl2_r <= axil_req.wdata[7:0];
			if (wa == `OFF_BAUD) baud_r <= axil_req.wdata[7:0];
			if (wa == `OFF_INTC) intc_r <= axil_req.wdata[7:0];
		end
	end

	// status access arms the clearing sequence; the data read consumes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_seen_r <= 1'b0;
		end else if (rd_status) begin
			status_seen_r <= 1'b1;
		end else if (rd_data) begin
			status_seen_r <= 1'b0;
		end
	end

	// overrun cleared by the two-step sequence, a new overrun wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_flag_r <= 1'b0;
			noise_flag_r <= 1'b0;
		end else begin
			if (overrun) overrun_flag_r <= 1'b1;
			else if (seq_clear) overrun_flag_r <= 1'b0;
			if (push & noise_fin) noise_flag_r <= 1'b1;
			else if (seq_clear) noise_flag_r <= 1'b0;
		end
	end

	// a full buffer keeps its words, the new one is dropped
	// receive-available falls when the last word is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) wr_ptr_r <= ~wr_ptr_r;
			if (pop) rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + 2'(push) - 2'(pop);
		end
	end

	rx_fifo_mem u_mem (
		.aclk(aclk),
		.we(push),
		.waddr(wr_ptr_r),
		.wdata(push_entry),
		.raddr(pop ? ~rd_ptr_r : rd_ptr_r),
		.rdata_r(head_r)
	);

	// baud divider gives sixteen ticks per bit
	always_ff @(posedge aclk) begin
		if (!aresetn || !run || tick) begin
			div_r <= 8'h0;
		end else begin
			div_r <= div_r + 8'h1;
		end
	end

	// take two samples ahead of the deciding one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_a_r <= 1'b1;
			s_b_r <= 1'b1;
		end else if (tick) begin
			if (samp_r == `SAMPLE_A) s_a_r <= rx_pin;
			if (samp_r == `SAMPLE_B) s_b_r <= rx_pin;
		end
	end

	// losing run (power-down) ends any frame in progress
	// the pin is ignored while the wake delay runs
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			st_r <= RX_IDLE;
			samp_r <= 4'h0;
			bit_r <= 4'h0;
			shift_r <= 9'h0;
			par_r <= 1'b0;
			fer_r <= 1'b0;
			per_r <= 1'b0;
			noise_r <= 1'b0;
		end else begin
			if (tick) samp_r <= samp_r + 4'h1;
			unique case (st_r)
				RX_IDLE: begin
					// start edge aligns the sample counter
					if (!rx_pin) begin
						st_r <= RX_START;
						samp_r <= 4'h0;
						bit_r <= 4'h0;
						par_r <= 1'b0;
						fer_r <= 1'b0;
						per_r <= 1'b0;
						noise_r <= 1'b0;
					end
				end
				RX_START: begin
					// a glitch that fails the vote is not a start bit
					if (decide) begin
						st_r <= maj ? RX_IDLE : RX_DATA;
						noise_r <= disagree;
					end
				end
				RX_DATA: begin
					if (decide) begin
						shift_r <= {maj, shift_r[8:1]};
						par_r <= par_r ^ maj;
						noise_r <= noise_fin;
						bit_r <= bit_r + 4'h1;
						if (bit_r == last_bit) st_r <= parity_en ? RX_PARITY : RX_STOP;
					end
				end
				RX_PARITY: begin
					if (decide) begin
						// checked only when parity is enabled
						per_r <= (par_r ^ maj) != parity_odd;
						noise_r <= noise_fin;
						st_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (decide) begin
						// a low stop bit is a framing error
						fer_r <= fer_fin;
						noise_r <= noise_fin;
						if (done) st_r <= fer_fin ? RX_WAIT_HIGH : RX_IDLE;
						else st_r <= RX_STOP2;
					end
				end
				RX_STOP2: begin
					// second stop bit must be high too
					if (decide) st_r <= fer_fin ? RX_WAIT_HIGH : RX_IDLE;
				end
				RX_WAIT_HIGH: begin
					// a long break is not taken as the next start bit
					if (rx_pin) st_r <= RX_IDLE;
				end
				default: st_r <= RX_IDLE;
			endcase
		end
	end

	// arming is taken as power-down is entered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_q_r <= 1'b0;
			armed_r <= 1'b0;
			rx_q_r <= 1'b1;
		end else begin
			pd_q_r <= power_down;
			rx_q_r <= rx_pin;
			if (power_down & ~pd_q_r) armed_r <= wake_en & port_en & rx_en & rx_ie;
			else if (!power_down) armed_r <= 1'b0;
		end
	end

	wire wake_go = power_down & armed_r & rx_q_r & ~rx_pin & ~wake_busy_r;

	// wake delay counter, then the interrupt is released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_busy_r <= 1'b0;
			wake_cnt_r <= 10'h0;
			wake_pend_r <= 1'b0;
		end else begin
			if (wake_go) begin
				wake_busy_r <= 1'b1;
				wake_cnt_r <= 10'(`WAKE_CYCLES - 1);
			end else if (wake_busy_r) begin
				wake_cnt_r <= wake_cnt_r - 10'h1;
				if (wake_cnt_r == 10'h0) wake_busy_r <= 1'b0;
			end
			// set wins over the status-read clear
			if (wake_busy_r & (wake_cnt_r == 10'h0)) wake_pend_r <= 1'b1;
			else if (rd_status) wake_pend_r <= 1'b0;
		end
	end

	// registered pins; the request is a level until its source clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_pin_r <= 1'b1;
			port_irq_r <= 1'b0;
			wake_event_r <= 1'b0;
		end else begin
			// transmit pin parked high in power-down
			tx_pin_r <= power_down | tx_line;
			port_irq_r <= irq_src & global_ie & port_ie & ~wake_busy_r;
			wake_event_r <= wake_go;
		end
	end

	assign axil_rsp = rsp_r;
	assign tx_pin = tx_pin_r;
	assign port_irq = port_irq_r;
	assign wake_event = wake_event_r;
endmodule // uart_rx_status_irq
